/* File: inc/ppc_pkg.sv */
/*
 * Constants for the parallel port control register block: register map,
 * field positions, masks, reset values and pin-mapping enumerations.
 * Assumes a 32-bit APB register bus with byte addresses on paddr.
 */
package ppc_pkg;

    localparam int ADDR_W = 8;

    // Register bases; each base except status owns four words: plain, clear, set, invert
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DOUT = 8'h10;
    localparam logic [7:0] OFS_DIN = 8'h20;
    localparam logic [7:0] OFS_PINS = 8'h30;
    localparam logic [7:0] OFS_STAT = 8'h40;

    // Word offsets of the aliases above each base
    localparam logic [7:0] OFS_CLR = 8'h04;
    localparam logic [7:0] OFS_SET = 8'h08;
    localparam logic [7:0] OFS_INV = 8'h0C;

    // Control register fields
    localparam int BIT_ON = 15;
    localparam int BIT_IDLE_STOP = 13;
    localparam int MUX_HI = 12;
    localparam int MUX_LO = 11;
    localparam int BIT_TTL = 10;
    localparam int BIT_WR_PIN_EN = 9;
    localparam int BIT_RD_PIN_EN = 8;
    localparam int CSF_HI = 7;
    localparam int CSF_LO = 6;
    localparam int BIT_LATCH_POL = 5;
    localparam int BIT_SEL_B_POL = 4;
    localparam int BIT_SEL_A_POL = 3;
    localparam int BIT_WR_POL = 1;
    localparam int BIT_RD_POL = 0;

    // Status register fields that software may clear by writing zero
    localparam int BIT_IN_OVERFLOW = 14;
    localparam int BIT_OUT_UNDERFLOW = 6;

    // Implemented bits of each register
    localparam logic [31:0] CTRL_MASK = 32'h0000BFFB;
    localparam logic [31:0] PINS_MASK = 32'h0000FFFF;
    localparam logic [31:0] DATA_MASK = 32'hFFFFFFFF;
    localparam logic [31:0] STAT_MASK = 32'h0000CFCF;
    localparam logic [31:0] STAT_STICKY = 32'h00004040;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam logic [31:0] PINS_RST = 32'h00000000;
    localparam logic [31:0] DATA_RST = 32'h00000000;
    localparam logic [31:0] STAT_RST = 32'h0000008F;

    typedef enum logic [1:0] {
        PPC_MUX_SEPARATE = 2'h0,
        PPC_MUX_LOW_BYTE = 2'h1,
        PPC_MUX_ALL_ON_8 = 2'h2,
        PPC_MUX_ALL_ON_16 = 2'h3
    } ppc_mux_e;

    typedef enum logic [1:0] {
        PPC_CSF_BOTH_ADDR = 2'h0,
        PPC_CSF_B_SELECT = 2'h1,
        PPC_CSF_BOTH_SELECT = 2'h2,
        PPC_CSF_RESERVED = 2'h3
    } ppc_csf_e;

    typedef enum logic [1:0] {
        PPC_ALIAS_PLAIN = 2'h0,
        PPC_ALIAS_CLR = 2'h1,
        PPC_ALIAS_SET = 2'h2,
        PPC_ALIAS_INV = 2'h3
    } ppc_alias_e;

endpackage

/* File: hw/ppc_pin_map.sv */
/*
 * Pin function mapper: turns control settings and engine activity into
 * next pin levels and active-low output enables.
 * Assumes all inputs are on pclk; the caller registers the results.
 */
`timescale 1ns/1ps
`default_nettype none

module ppc_pin_map
(
    // Control settings
    input wire logic enable,
    input wire logic [1:0] mux_sel,
    input wire logic [1:0] chip_select_function,
    input wire logic latch_pol,
    input wire logic sel_a_pol,
    input wire logic sel_b_pol,
    input wire logic wr_pol,
    input wire logic rd_pol,
    input wire logic wr_pin_en,
    input wire logic rd_pin_en,
    input wire logic [15:0] pins,
    // Engine activity
    input wire logic [15:0] ext_addr,
    input wire logic sel_a_act,
    input wire logic sel_b_act,
    input wire logic latch_lo_act,
    input wire logic latch_hi_act,
    input wire logic wr_act,
    input wire logic rd_act,
    // Next pin values
    output logic [15:0] next_addr,
    output logic [15:0] next_addr_oe_n,
    output logic [1:0] next_latch,
    output logic [1:0] next_latch_oe_n,
    output logic next_wr,
    output logic next_wr_oe_n,
    output logic next_rd,
    output logic next_rd_oe_n
);

    logic b_is_select;
    logic a_is_select;
    logic muxed;

    // Reserved chip-select code behaves as plain address lines
    assign b_is_select = (chip_select_function == ppc_pkg::PPC_CSF_B_SELECT)
                      || (chip_select_function == ppc_pkg::PPC_CSF_BOTH_SELECT);
    assign a_is_select = (chip_select_function == ppc_pkg::PPC_CSF_BOTH_SELECT);
    assign muxed = (mux_sel != ppc_pkg::PPC_MUX_SEPARATE);

    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1)
        begin : g_addr
            logic used;
            logic value;
            always_comb
            begin
                used = 1'b1;
                value = ext_addr[i];
                if (i < 8)
                begin
                    used = !muxed;
                end
                else if (mux_sel[1])
                begin
                    used = 1'b0;
                end
                if (i == 15 && b_is_select)
                begin
                    used = 1'b1;
                    value = sel_b_act ~^ sel_b_pol;
                end
                if (i == 14 && a_is_select)
                begin
                    used = 1'b1;
                    value = sel_a_act ~^ sel_a_pol;
                end
            end
            assign next_addr[i] = value;
            assign next_addr_oe_n[i] = !(enable && pins[i] && used);
        end
    endgenerate

    // latch strobes only in multiplexed modes
    assign next_latch = {latch_hi_act ~^ latch_pol, latch_lo_act ~^ latch_pol};
    assign next_latch_oe_n = {2{!(enable && muxed)}};

    assign next_wr = wr_act ~^ wr_pol;
    assign next_wr_oe_n = !(enable && wr_pin_en);
    assign next_rd = rd_act ~^ rd_pol;
    assign next_rd_oe_n = !(enable && rd_pin_en);

endmodule

`default_nettype wire

/* File: hw/ppc_port_ctrl.sv */
/*
 * Control and status register set of an 8/16-bit parallel port, with
 * clear/set/invert aliases, pin function mapping and enable sequencing.
 * Assumes an APB master on pclk and a transfer engine on pclk that
 * drives the activity inputs and consumes the run level and the abort/reset pulses.
 */
// The placing of the registers and the APB register port were chosen for this implementation.
// What this block does
// - Clear alias four bytes above each register except status clears written one bits
// - Set alias eight bytes above each register except status sets written one bits
// - Invert alias twelve bytes above each register except status toggles written one bits
// - Unimplemented bits, control upper half included, read zero, writes ignored
// - Control bit 15 enables the port; cleared means no external access
// - Control bit 13 halts operation while the device idles
// - Two-bit multiplex field chooses where address bits appear
// - Control bit 9 enables the write/enable strobe pin
// - Control bit 8 enables the read/read-write strobe pin
// - Chip-select function field picks address or select use of pins
// - Control bit 5 sets both address latch strobe polarities
// - Control bit 4 sets second chip-select polarity
// - Select and latch settings do nothing on pins used as address
// - Control bit 3 sets first chip-select polarity
// - Control bits 1 and 0 set write and read strobe polarity
// - Clearing enable aborts transfers, clears busy, releases pins, keeps data
// - Setting enable resets buffer logic and the buffer status register
`timescale 1ns/1ps
`default_nettype none

module ppc_port_ctrl
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ppc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device power state
    input wire logic idle_req,
    // Transfer engine side
    input wire logic [15:0] ext_addr,
    input wire logic sel_a_act,
    input wire logic sel_b_act,
    input wire logic latch_lo_act,
    input wire logic latch_hi_act,
    input wire logic wr_act,
    input wire logic rd_act,
    input wire logic din_load,
    input wire logic [31:0] din_value,
    input wire logic [15:0] stat_set,
    input wire logic [15:0] stat_clr,
    output logic engine_run,
    output logic xfer_abort,
    output logic buffer_reset,
    output logic input_level_ttl,
    output logic [31:0] dout_word,
    output logic [31:0] din_word,
    // External pins
    output logic [15:0] bus_address_pins,
    output logic [15:0] bus_address_pins_oe_n,
    output logic addr_latch_low,
    output logic addr_latch_low_oe_n,
    output logic addr_latch_high,
    output logic addr_latch_high_oe_n,
    output logic write_strobe,
    output logic write_strobe_oe_n,
    output logic read_strobe,
    output logic read_strobe_oe_n
);

    logic [31:0] port_control;
    logic [31:0] pin_allocation;
    logic [31:0] slave_output_data;
    logic [31:0] slave_buffer_status;
    logic enable_prev;
    logic setup;
    logic wr_fire;
    logic [7:0] base;
    logic [1:0] kind;
    logic mapped;
    logic [31:0] wmask;
    logic en_rise;
    logic en_fall;
    logic run;
    logic [31:0] read_value;
    logic [15:0] next_addr;
    logic [15:0] next_addr_oe_n;
    logic [1:0] next_latch;
    logic [1:0] next_latch_oe_n;
    logic next_wr;
    logic next_wr_oe_n;
    logic next_rd;
    logic next_rd_oe_n;

    // Applies one plain or alias write to a register through its masks
    function automatic logic [31:0] ppc_apply(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [1:0] how,
                                              input logic [31:0] m);
        logic [31:0] bits;
        bits = wd & m;
        case (how)
            ppc_pkg::PPC_ALIAS_PLAIN: ppc_apply = (old & ~m) | bits;
            ppc_pkg::PPC_ALIAS_CLR: ppc_apply = old & ~bits;
            ppc_pkg::PPC_ALIAS_SET: ppc_apply = old | bits;
            ppc_pkg::PPC_ALIAS_INV: ppc_apply = old ^ bits;
            default: ppc_apply = old;
        endcase
    endfunction

    assign setup = psel && !penable;
    assign wr_fire = psel && penable && pready && pwrite && !pslverr;
    assign base = {paddr[7:4], 4'h0};
    assign kind = paddr[3:2];
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign en_rise = port_control[ppc_pkg::BIT_ON] && !enable_prev;
    assign en_fall = !port_control[ppc_pkg::BIT_ON] && enable_prev;
    assign run = port_control[ppc_pkg::BIT_ON]
              && !(port_control[ppc_pkg::BIT_IDLE_STOP] && idle_req);

    // Status has no aliases; misaligned and other bases are errors
    always_comb
    begin
        mapped = 1'b0;
        read_value = 32'h00000000;
        if (paddr[1:0] == 2'h0)
        begin
            case (base)
                ppc_pkg::OFS_CTRL:
                begin
                    mapped = 1'b1;
                    read_value = port_control;
                end
                ppc_pkg::OFS_DOUT:
                begin
                    mapped = 1'b1;
                    read_value = slave_output_data;
                end
                ppc_pkg::OFS_DIN:
                begin
                    mapped = 1'b1;
                    read_value = din_word;
                end
                ppc_pkg::OFS_PINS:
                begin
                    mapped = 1'b1;
                    read_value = pin_allocation;
                end
                ppc_pkg::OFS_STAT:
                begin
                    mapped = (kind == ppc_pkg::PPC_ALIAS_PLAIN);
                    read_value = slave_buffer_status;
                end
                default:
                begin
                    mapped = 1'b0;
                end
            endcase
            if (kind != ppc_pkg::PPC_ALIAS_PLAIN)
            begin
                read_value = 32'h00000000;
            end
        end
    end

    // No wait state: the answer is prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else if (setup)
        begin
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= pwrite ? 32'h00000000 : read_value;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_control <= ppc_pkg::CTRL_RST;
        end
        else if (wr_fire && base == ppc_pkg::OFS_CTRL)
        begin
            port_control <= ppc_apply(port_control, pwdata, kind,
                                      wmask & ppc_pkg::CTRL_MASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_allocation <= ppc_pkg::PINS_RST;
        end
        else if (wr_fire && base == ppc_pkg::OFS_PINS)
        begin
            pin_allocation <= ppc_apply(pin_allocation, pwdata, kind,
                                        wmask & ppc_pkg::PINS_MASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slave_output_data <= ppc_pkg::DATA_RST;
        end
        else if (wr_fire && base == ppc_pkg::OFS_DOUT)
        begin
            slave_output_data <= ppc_apply(slave_output_data, pwdata, kind,
                                           wmask & ppc_pkg::DATA_MASK);
        end
    end

    // Engine load beats a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            din_word <= ppc_pkg::DATA_RST;
        end
        else if (din_load)
        begin
            din_word <= din_value;
        end
        else if (wr_fire && base == ppc_pkg::OFS_DIN)
        begin
            din_word <= ppc_apply(din_word, pwdata, kind,
                                  wmask & ppc_pkg::DATA_MASK);
        end
    end

    // enable rise restores status; set wins over clear otherwise
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slave_buffer_status <= ppc_pkg::STAT_RST;
        end
        else if (en_rise)
        begin
            slave_buffer_status <= ppc_pkg::STAT_RST;
        end
        else
        begin
            slave_buffer_status <= ((slave_buffer_status
                & ~{16'h0000, stat_clr}
                & ~((wr_fire && base == ppc_pkg::OFS_STAT)
                    ? (ppc_pkg::STAT_STICKY & wmask & ~pwdata) : 32'h00000000))
                | {16'h0000, stat_set}) & ppc_pkg::STAT_MASK;
        end
    end

    // enable edge pulses, run level, TTL select and output word registered for the engine
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_prev <= 1'b0;
            xfer_abort <= 1'b0;
            buffer_reset <= 1'b0;
            engine_run <= 1'b0;
            input_level_ttl <= 1'b0;
            dout_word <= ppc_pkg::DATA_RST;
        end
        else
        begin
            enable_prev <= port_control[ppc_pkg::BIT_ON];
            xfer_abort <= en_fall;
            buffer_reset <= en_rise;
            engine_run <= run;
            input_level_ttl <= port_control[ppc_pkg::BIT_TTL];
            dout_word <= slave_output_data;
        end
    end

    ppc_pin_map u_pin_map
    (
        .enable(port_control[ppc_pkg::BIT_ON]),
        .mux_sel(port_control[ppc_pkg::MUX_HI:ppc_pkg::MUX_LO]),
        .chip_select_function(port_control[ppc_pkg::CSF_HI:ppc_pkg::CSF_LO]),
        .latch_pol(port_control[ppc_pkg::BIT_LATCH_POL]),
        .sel_a_pol(port_control[ppc_pkg::BIT_SEL_A_POL]),
        .sel_b_pol(port_control[ppc_pkg::BIT_SEL_B_POL]),
        .wr_pol(port_control[ppc_pkg::BIT_WR_POL]),
        .rd_pol(port_control[ppc_pkg::BIT_RD_POL]),
        .wr_pin_en(port_control[ppc_pkg::BIT_WR_PIN_EN]),
        .rd_pin_en(port_control[ppc_pkg::BIT_RD_PIN_EN]),
        .pins(pin_allocation[15:0]),
        .ext_addr(ext_addr),
        .sel_a_act(sel_a_act && run),
        .sel_b_act(sel_b_act && run),
        .latch_lo_act(latch_lo_act && run),
        .latch_hi_act(latch_hi_act && run),
        .wr_act(wr_act && run),
        .rd_act(rd_act && run),
        .next_addr(next_addr),
        .next_addr_oe_n(next_addr_oe_n),
        .next_latch(next_latch),
        .next_latch_oe_n(next_latch_oe_n),
        .next_wr(next_wr),
        .next_wr_oe_n(next_wr_oe_n),
        .next_rd(next_rd),
        .next_rd_oe_n(next_rd_oe_n)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_address_pins <= 16'h0000;
            bus_address_pins_oe_n <= 16'hFFFF;
            addr_latch_low <= 1'b0;
            addr_latch_low_oe_n <= 1'b1;
            addr_latch_high <= 1'b0;
            addr_latch_high_oe_n <= 1'b1;
            write_strobe <= 1'b0;
            write_strobe_oe_n <= 1'b1;
            read_strobe <= 1'b0;
            read_strobe_oe_n <= 1'b1;
        end
        else
        begin
            bus_address_pins <= next_addr;
            bus_address_pins_oe_n <= next_addr_oe_n;
            addr_latch_low <= next_latch[0];
            addr_latch_low_oe_n <= next_latch_oe_n[0];
            addr_latch_high <= next_latch[1];
            addr_latch_high_oe_n <= next_latch_oe_n[1];
            write_strobe <= next_wr;
            write_strobe_oe_n <= next_wr_oe_n;
            read_strobe <= next_rd;
            read_strobe_oe_n <= next_rd_oe_n;
        end
    end

    a_clr_alias_bits: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_fire && paddr == (ppc_pkg::OFS_CTRL | ppc_pkg::OFS_CLR))
        |=> ((port_control & $past(pwdata) & $past(wmask) & ppc_pkg::CTRL_MASK) == 32'h0))
        else $error("clear alias left a bit set");

    a_set_alias_bits: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_fire && paddr == (ppc_pkg::OFS_PINS | ppc_pkg::OFS_SET))
        |=> ((pin_allocation & $past(pwdata & wmask) & ppc_pkg::PINS_MASK)
             == ($past(pwdata & wmask) & ppc_pkg::PINS_MASK)))
        else $error("set alias missed a bit");

    a_inv_alias_bits: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_fire && paddr == (ppc_pkg::OFS_DOUT | ppc_pkg::OFS_INV))
        |=> (slave_output_data == ($past(slave_output_data) ^ $past(pwdata & wmask))))
        else $error("invert alias result wrong");

    a_reserved_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == ppc_pkg::OFS_CTRL) |=> (prdata[31:16] == 16'h0000 && pready))
        else $error("reserved control bits read nonzero");

    a_disabled_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
        !port_control[ppc_pkg::BIT_ON] |=> (&bus_address_pins_oe_n && write_strobe_oe_n
            && read_strobe_oe_n && addr_latch_low_oe_n))
        else $error("pins driven while disabled");

    a_idle_halts_run: assert property (@(posedge pclk) disable iff (!presetn)
        (port_control[ppc_pkg::BIT_IDLE_STOP] && idle_req) |=> !engine_run)
        else $error("engine runs in idle with stop set");

    a_mux16_addr_free: assert property (@(posedge pclk) disable iff (!presetn)
        (port_control[ppc_pkg::MUX_HI:ppc_pkg::MUX_LO] == ppc_pkg::PPC_MUX_ALL_ON_16)
        |=> (&bus_address_pins_oe_n[13:0]))
        else $error("address pins driven with all address on data");

    a_wr_pin_off: assert property (@(posedge pclk) disable iff (!presetn)
        !port_control[ppc_pkg::BIT_WR_PIN_EN] |=> write_strobe_oe_n)
        else $error("write strobe driven while its pin is off");

    a_csf_addr_line: assert property (@(posedge pclk) disable iff (!presetn)
        (port_control[ppc_pkg::CSF_HI:ppc_pkg::CSF_LO] == ppc_pkg::PPC_CSF_BOTH_ADDR)
        |=> (bus_address_pins[15:14] == $past(ext_addr[15:14])))
        else $error("select setting touched an address line");

    a_disable_aborts: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(port_control[ppc_pkg::BIT_ON]) |-> ##1 xfer_abort ##1 !xfer_abort)
        else $error("no single abort pulse on disable");

    a_enable_resets_buf: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(port_control[ppc_pkg::BIT_ON])
        |=> (buffer_reset && slave_buffer_status == ppc_pkg::STAT_RST))
        else $error("enable did not reset buffer status");

endmodule

`default_nettype wire

/* File: testbench/ppc_ext_model.sv */
/*
 * Far-side model of one strobe line of the parallel port.
 * Assumes the port gives a pin level and an active-low enable.
 */
`timescale 1ns/1ps
`default_nettype none

module ppc_ext_model
(
    // Pin from the port
    input wire logic pin,
    input wire logic pin_oe_n,
    // Level seen by the peripheral
    output logic line
);
    // Released line floats up to the board pull-up
    assign line = pin_oe_n ? 1'b1 : pin;
endmodule

`default_nettype wire

/* File: testbench/ppc_port_ctrl_tb.sv */
/*
 * Testbench of the parallel port control registers over APB.
 * Assumes a single pclk domain and the register map of ppc_pkg.
 */
`timescale 1ns/1ps
`default_nettype none

module ppc_port_ctrl_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [15:0] ext = 0, pa, pa_oe_n;
    logic [5:0] act = 0;
    logic idle_req = 0, pready, pslverr, err, run, abort, bres;
    logic all, wr, wr_oe_n, rd_oe_n, wr_line;
    logic ttl, rds, alh, alh_oe_n, all_oe_n;
    logic [31:0] dout, din;
    logic [15:0] sclr = 0;
    int failures = 0, checks = 0, aborts = 0, bresets = 0;
    logic [15:0] mux_exp [4] = '{16'h0FF0, 16'h0FFF, 16'hFFFF, 16'hFFFF};
    logic [1:0] csf_exp [4] = '{2'b01, 2'b11, 2'b11, 2'b01};

    always #20 pclk = ~pclk;

    always @(posedge pclk)
    begin
        if (abort === 1'b1) aborts++;
        if (bres === 1'b1) bresets++;
    end

    ppc_port_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .idle_req(idle_req), .ext_addr(ext), .sel_a_act(act[0]),
        .sel_b_act(act[1]), .latch_lo_act(act[2]), .latch_hi_act(act[3]),
        .wr_act(act[4]), .rd_act(act[5]), .din_load(1'b0),
        .din_value(32'h0), .stat_set(16'h0), .stat_clr(sclr),
        .engine_run(run), .xfer_abort(abort), .buffer_reset(bres),
        .input_level_ttl(ttl), .dout_word(dout), .din_word(din),
        .bus_address_pins(pa), .bus_address_pins_oe_n(pa_oe_n),
        .addr_latch_low(all), .addr_latch_low_oe_n(all_oe_n), .addr_latch_high(alh),
        .addr_latch_high_oe_n(alh_oe_n), .write_strobe(wr),
        .write_strobe_oe_n(wr_oe_n), .read_strobe(rds),
        .read_strobe_oe_n(rd_oe_n));

    ppc_ext_model ext_u (.pin(wr), .pin_oe_n(wr_oe_n), .line(wr_line));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task ap(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16)
        begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1)
        begin
            failures++;
            $display("mismatch at %0t: no pready", $time);
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rc(input logic [7:0] a, input logic [31:0] exp);
        ap(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Write, then let the registered pins follow
    task wp(input logic [7:0] a, input logic [31:0] d);
        ap(1'b1, a, d);
        repeat (3) @(posedge pclk);
    endtask

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rc(8'h00, 32'h0);
        chk(wr_line, 1'b1);
        wp(8'h00, 32'hFFFF7FFF);
        rc(8'h00, 32'h00003FFB);
        chk(ttl, 1'b1);
        wp(8'h30, 32'h000000FF);
        wp(8'h34, 32'h0000000F);
        rc(8'h30, 32'h000000F0);
        wp(8'h38, 32'h0000FF00);
        rc(8'h30, 32'h0000FFF0);
        wp(8'h3C, 32'hFFFF0FFF);
        rc(8'h30, 32'h0000F00F);
        rc(8'h3C, 32'h0);
        wp(8'h1C, 32'hA5A5A5A5);
        rc(8'h10, 32'hA5A5A5A5);
        chk(dout, 32'hA5A5A5A5);
        wp(8'h28, 32'h0000FF00);
        rc(8'h20, 32'h0000FF00);
        chk(din, 32'h0000FF00);
        // Status word has no aliases
        ap(1'b1, 8'h44, 32'h1);
        chk(err, 1'b1);
        rc(8'h40, 32'h0000008F);
        // Engine empties the output flags while disabled
        sclr <= 16'h000F;
        @(posedge pclk);
        sclr <= 16'h0000;
        rc(8'h40, 32'h00000080);
        act <= 6'h3F;
        ext <= 16'h5A3C;
        wp(8'h00, 32'h00008200);
        chk(wr_oe_n, 1'b0);
        chk(wr_line, 1'b0);
        chk(wr, 1'b0);
        chk(rds, 1'b0);
        chk(rd_oe_n, 1'b1);
        chk(bresets, 1);
        rc(8'h40, 32'h0000008F);
        for (int m = 0; m < 4; m++)
        begin
            wp(8'h00, 32'h00008000 | (m << 11));
            chk(pa_oe_n, mux_exp[m]);
        end
        for (int c = 0; c < 4; c++)
        begin
            wp(8'h00, 32'h00008838 | (c << 6));
            chk(pa[15:14], csf_exp[c]);
        end
        chk(all, 1'b1);
        chk({alh, alh_oe_n, all_oe_n}, 3'b100);
        wp(8'h00, 32'h00008880);
        chk(pa[15:14], 2'b00);
        chk(all, 1'b0);
        wp(8'h00, 32'h00008203);
        chk(wr, 1'b1);
        chk(rds, 1'b1);
        idle_req <= 1'b1;
        wp(8'h00, 32'h0000A000);
        chk(run, 1'b0);
        idle_req <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(run, 1'b1);
        wp(8'h00, 32'h00002000);
        chk(aborts, 1);
        chk(pa_oe_n, 16'hFFFF);
        // Extra idle cycle after disable before the next access
        @(posedge pclk);
        rc(8'h00, 32'h00002000);
        wp(8'h04, 32'h00002000);
        rc(8'h00, 32'h0);
        test_done();
    end
endmodule

`default_nettype wire
